// ### rtl/pdr_map.vh
// Register map, field layout, state codes and limits of the power-dip restart block
`ifndef PDR_MAP_VH
`define PDR_MAP_VH

`define PDR_AW 6
`define PDR_A_MODE 6'h00
`define PDR_A_UPPER 6'h04
`define PDR_A_LOWER 6'h08
`define PDR_A_START 6'h0C
`define PDR_A_STOP 6'h10
`define PDR_A_GAIN 6'h14
`define PDR_A_STATUS 6'h18
`define PDR_A_IRQ 6'h1C
`define PDR_A_MASK 6'h20
`define PDR_A_FREQ 6'h24

`define PDR_F_RMODE 2:0
`define PDR_F_GUARD 5:4
`define PDR_F_TORQUE 11:8
`define PDR_B_MOTOR1 12
`define PDR_B_SEARCH 13

`define PDR_MODE_RST 3'h0
`define PDR_GUARD_RST 2'h0
`define PDR_UPPER_RST 16'h0FA0
`define PDR_LOWER_RST 16'h0000
`define PDR_START_RST 16'h0005
`define PDR_STOP_RST 16'h0002
`define PDR_GAIN_RST 16'h0808

`define PDR_M0 3'h0
`define PDR_M1 3'h1
`define PDR_M2 3'h2
`define PDR_M3 3'h3
`define PDR_M4 3'h4
`define PDR_M5 3'h5

`define PDR_G_OFF 2'h0
`define PDR_G_INT 2'h1
`define PDR_G_EXT 2'h2

// Frequencies in 0.1 Hz units
`define PDR_FMAX_WIDE 16'h0FA0
`define PDR_FMAX_NARROW 16'h04B0
`define PDR_SS_MIN 16'h0032
`define PDR_SS_MAX 16'h03E8

`define PDR_UV_CODE 8'h4C
`define PDR_RAMP 16'h0001
`define PDR_FAST 16'h0002
`define PDR_RIDE_SH 6

`define PDR_S_IDLE 3'h0
`define PDR_S_RUN 3'h1
`define PDR_S_STOP 3'h2
`define PDR_S_DECEL 3'h3
`define PDR_S_RIDE 3'h4
`define PDR_S_WAIT 3'h5
`define PDR_S_TRIP 3'h6

`define PDR_EV_TRIP 0
`define PDR_EV_DIP 1
`define PDR_EV_RESTART 2
`define PDR_EV_REFUSE 3

`endif

// ### rtl/pdr_core.v
// Power-dip restart sequencer, frequency clamp and braking-resistor guard select
//
// Overview of operation
// - Braking guard select takes 0, 1 or 2; large drives accept only 0.
// - Restart mode selector takes values zero to five, each a distinct reaction.
// - Mode 0: undervoltage trips at once; reset plus fresh run needed to restart.
// - Mode 1: undervoltage stops output; fault raised at recovery; reset restarts.
// - Mode 2: bus at continue level gives fast controlled stop, then fault.
// - Mode 3: ride through; recovery accelerates back, else restart at held frequency.
// - Mode 4: undervoltage stops output; recovery restarts at frequency at failure.
// - Mode 5: undervoltage stops output; recovery restarts from start frequency.
// - Torque control nonzero with motor 1 makes modes 2 to 5 act as mode 1.
// - Ride-through regulator uses separate integral and proportional gain settings.
// - Speed-search pickup only for detected speeds 5 to 100 Hz, else regular restart.
// - Setting frequency clamped between limits, each written up to 400 or 120 Hz; upper resets to 400 Hz.
// - Upper limit wins when set below the lower limit.
// - With a lower limit and run asserted, run at lower limit for 0 Hz command.
// - Output starts at start frequency and ends at stop frequency.
// - Refuse start if start or setting frequency is below stop frequency.
`timescale 1ns/1ns
`include "pdr_map.vh"

module pdr_core (
  input wire i_clk, // 250 MHz clock
  input wire i_resetn, // Asynchronous reset, active low
  input wire [5:0] i_addr, // Register byte address
  input wire [31:0] i_wdata, // Register write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  input wire i_large_drive, // High when the drive capacity is a large one
  input wire i_narrow_range, // High on the 120 Hz model variant
  input wire i_run, // Run command level
  input wire i_reset_cmd, // Fault reset command
  input wire [15:0] i_freq_cmd, // Frequency command, 0.1 Hz units
  input wire i_undervolt, // Supply undervoltage detected
  input wire i_recovered, // Supply recovered
  input wire i_bus_low, // DC bus at or below continue-operation level
  input wire [7:0] i_bus_deficit, // DC bus shortfall below the hold level
  input wire [15:0] i_motor_speed, // Detected coasting speed, 0.1 Hz units
  output reg [31:0] o_rdata, // Read data, cycle after the read strobe
  output reg [15:0] o_freq_target, // Output-frequency target
  output reg o_output_on, // Output stage enabled
  output reg o_fault, // Undervoltage fault indication
  output reg [7:0] o_fault_code, // Fault code shown while faulted
  output reg [1:0] o_brake_guard, // Braking-resistor guard select
  output reg o_irq // Level interrupt
);

  reg [2:0] rmode_q;
  reg [1:0] guard_q;
  reg [3:0] torque_q;
  reg motor1_q;
  reg search_q;
  reg [15:0] upper_q;
  reg [15:0] lower_q;
  reg [15:0] start_q;
  reg [15:0] stop_q;
  reg [15:0] gain_q;
  reg [3:0] stat_q;
  reg [3:0] mask_q;

  reg [2:0] st_q;
  reg [2:0] st_d;
  reg [15:0] freq_d;
  reg on_d;
  reg fault_d;
  reg [15:0] hold_q;
  reg [15:0] hold_d;
  reg fresh_q;
  reg fresh_d;
  reg [15:0] acc_q;
  reg [15:0] acc_d;
  reg [3:0] ev_d;

  wire [15:0] fmax;
  wire [15:0] aim;
  wire [2:0] eff_mode;
  wire active;
  wire [15:0] prop;
  wire [15:0] ride_step;
  wire [15:0] ride_sum;

  function [15:0] clamp_freq;
    input [15:0] f;
    input [15:0] lo;
    input [15:0] hi;
    reg [15:0] t;
    begin
      t = (f < lo) ? lo : f;
      clamp_freq = (t > hi) ? hi : t;
    end
  endfunction

  function [15:0] ramp;
    input [15:0] cur;
    input [15:0] goal;
    input [15:0] step;
    begin
      if (cur + step <= goal)
        ramp = cur + step;
      else if (cur >= goal + step)
        ramp = cur - step;
      else
        ramp = goal;
    end
  endfunction

  function [15:0] pick;
    input en;
    input [15:0] spd;
    input [15:0] fallback;
    begin
      if (en && spd >= `PDR_SS_MIN && spd <= `PDR_SS_MAX)
        pick = spd;
      else
        pick = fallback;
    end
  endfunction

  function [15:0] mul8;
    input [7:0] a;
    input [7:0] b;
    begin
      mul8 = a * b;
    end
  endfunction

  function [15:0] lim;
    input [31:0] v;
    input [15:0] top;
    begin
      lim = (v[15:0] > top || v[31:16] != 16'h0000) ? top : v[15:0];
    end
  endfunction

  // Clamp ceiling depends on model variant
  assign fmax = i_narrow_range ? `PDR_FMAX_NARROW : `PDR_FMAX_WIDE;
  // Lower limit first, upper applied last so it overrides
  assign aim = clamp_freq(i_freq_cmd, lower_q, upper_q);
  assign eff_mode = (torque_q != 4'h0 && motor1_q && rmode_q >= `PDR_M2) ?
    `PDR_M1 : rmode_q;
  assign active = (st_q == `PDR_S_RUN) || (st_q == `PDR_S_STOP);
  assign prop = mul8(gain_q[15:8], i_bus_deficit);
  assign ride_sum = prop + acc_q;
  assign ride_step = (ride_sum >> `PDR_RIDE_SH) | `PDR_RAMP;

  always @* begin
    st_d = st_q;
    freq_d = o_freq_target;
    on_d = o_output_on;
    fault_d = o_fault;
    hold_d = hold_q;
    fresh_d = fresh_q & i_run;
    acc_d = acc_q;
    ev_d = 4'h0;
    case (st_q)
      `PDR_S_IDLE: begin
        on_d = 1'b0;
        freq_d = 16'h0000;
        if (i_run && !fresh_q && !i_undervolt) begin
          if (start_q < stop_q || aim < stop_q) begin
            ev_d[`PDR_EV_REFUSE] = 1'b1;
            fresh_d = 1'b1;
          end else begin
            st_d = `PDR_S_RUN;
            on_d = 1'b1;
            freq_d = start_q;
          end
        end
      end
      `PDR_S_RUN: begin
        if (!i_run)
          st_d = `PDR_S_STOP;
        else
          freq_d = ramp(o_freq_target, aim, `PDR_RAMP);
      end
      `PDR_S_STOP: begin
        if (i_run) begin
          st_d = `PDR_S_RUN;
        end else if (o_freq_target <= stop_q) begin
          st_d = `PDR_S_IDLE;
          on_d = 1'b0;
          freq_d = 16'h0000;
        end else begin
          freq_d = ramp(o_freq_target, stop_q, `PDR_RAMP);
        end
      end
      `PDR_S_DECEL: begin
        if (i_undervolt) begin
          st_d = `PDR_S_TRIP;
        end else if (o_freq_target <= stop_q) begin
          st_d = `PDR_S_TRIP;
        end else begin
          // Shortened deceleration to return load energy faster
          freq_d = ramp(o_freq_target, stop_q, `PDR_FAST);
        end
      end
      `PDR_S_RIDE: begin
        if (i_undervolt) begin
          st_d = `PDR_S_WAIT;
          on_d = 1'b0;
          hold_d = o_freq_target;
          ev_d[`PDR_EV_DIP] = 1'b1;
        end else if (i_recovered || !i_bus_low) begin
          st_d = `PDR_S_RUN;
        end else begin
          acc_d = acc_q + mul8(gain_q[7:0], i_bus_deficit);
          freq_d = (o_freq_target > ride_step) ?
            o_freq_target - ride_step : 16'h0000;
        end
      end
      `PDR_S_WAIT: begin
        on_d = 1'b0;
        if (i_recovered && !i_undervolt) begin
          ev_d[`PDR_EV_RESTART] = 1'b1;
          case (eff_mode)
            `PDR_M3, `PDR_M4: begin
              st_d = `PDR_S_RUN;
              on_d = 1'b1;
              freq_d = pick(search_q, i_motor_speed, hold_q);
            end
            `PDR_M5: begin
              st_d = `PDR_S_RUN;
              on_d = 1'b1;
              freq_d = pick(search_q, i_motor_speed, start_q);
            end
            default: begin
              st_d = `PDR_S_TRIP;
              ev_d[`PDR_EV_RESTART] = 1'b0;
            end
          endcase
        end
      end
      `PDR_S_TRIP: begin
        on_d = 1'b0;
        freq_d = 16'h0000;
        fault_d = 1'b1;
        if (i_reset_cmd) begin
          st_d = `PDR_S_IDLE;
          fault_d = 1'b0;
          // Mode 1 restarts on reset alone; the others need a new run edge
          fresh_d = (eff_mode != `PDR_M1);
        end
      end
      default: begin
        st_d = `PDR_S_IDLE;
        on_d = 1'b0;
      end
    endcase

    if (active) begin
      if (i_undervolt) begin
        ev_d[`PDR_EV_DIP] = 1'b1;
        hold_d = o_freq_target;
        if (eff_mode == `PDR_M0 || eff_mode == `PDR_M2) begin
          st_d = `PDR_S_TRIP;
        end else begin
          st_d = `PDR_S_WAIT;
          on_d = 1'b0;
        end
      end else if (i_bus_low && eff_mode == `PDR_M2) begin
        st_d = `PDR_S_DECEL;
        ev_d[`PDR_EV_DIP] = 1'b1;
      end else if (i_bus_low && eff_mode == `PDR_M3) begin
        st_d = `PDR_S_RIDE;
        acc_d = 16'h0000;
        ev_d[`PDR_EV_DIP] = 1'b1;
      end
    end

    if (st_d == `PDR_S_TRIP && st_q != `PDR_S_TRIP) begin
      ev_d[`PDR_EV_TRIP] = 1'b1;
      fault_d = 1'b1;
      on_d = 1'b0;
      freq_d = 16'h0000;
    end
  end

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q <= `PDR_S_IDLE;
      o_freq_target <= 16'h0000;
      o_output_on <= 1'b0;
      o_fault <= 1'b0;
      o_fault_code <= 8'h00;
      hold_q <= 16'h0000;
      fresh_q <= 1'b0;
      acc_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      o_freq_target <= freq_d;
      o_output_on <= on_d;
      o_fault <= fault_d;
      o_fault_code <= fault_d ? `PDR_UV_CODE : 8'h00;
      hold_q <= hold_d;
      fresh_q <= fresh_d;
      acc_q <= acc_d;
    end
  end

  // Register writes
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rmode_q <= `PDR_MODE_RST;
      guard_q <= `PDR_GUARD_RST;
      torque_q <= 4'h0;
      motor1_q <= 1'b1;
      search_q <= 1'b0;
      upper_q <= `PDR_UPPER_RST;
      lower_q <= `PDR_LOWER_RST;
      start_q <= `PDR_START_RST;
      stop_q <= `PDR_STOP_RST;
      gain_q <= `PDR_GAIN_RST;
      stat_q <= 4'h0;
      mask_q <= 4'h0;
    end else begin
      // New events beat a same-cycle clear
      stat_q <= (stat_q & ~((i_wr && i_addr == `PDR_A_IRQ) ?
        i_wdata[3:0] : 4'h0)) | ev_d;
      // Large capacity limits can arrive later than the stored setting
      if (i_large_drive)
        guard_q <= `PDR_G_OFF;
      if (i_wr) begin
        case (i_addr)
          `PDR_A_MODE: begin
            if (i_wdata[`PDR_F_RMODE] <= `PDR_M5)
              rmode_q <= i_wdata[`PDR_F_RMODE];
            if (i_wdata[`PDR_F_GUARD] == `PDR_G_OFF ||
                (!i_large_drive && i_wdata[`PDR_F_GUARD] <= `PDR_G_EXT))
              guard_q <= i_wdata[`PDR_F_GUARD];
            torque_q <= i_wdata[`PDR_F_TORQUE];
            motor1_q <= i_wdata[`PDR_B_MOTOR1];
            search_q <= i_wdata[`PDR_B_SEARCH];
          end
          `PDR_A_UPPER: upper_q <= lim(i_wdata, fmax);
          `PDR_A_LOWER: lower_q <= lim(i_wdata, fmax);
          `PDR_A_START: start_q <= i_wdata[15:0];
          `PDR_A_STOP: stop_q <= i_wdata[15:0];
          `PDR_A_GAIN: gain_q <= i_wdata[15:0];
          `PDR_A_MASK: mask_q <= i_wdata[3:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Read data and interrupt output
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
      o_irq <= 1'b0;
      o_brake_guard <= `PDR_GUARD_RST;
    end else begin
      o_irq <= |(stat_q & mask_q);
      o_brake_guard <= guard_q;
      o_rdata <= 32'h00000000;
      if (i_rd) begin
        case (i_addr)
          `PDR_A_MODE: o_rdata <= {18'h00000, search_q, motor1_q, torque_q,
            2'h0, guard_q, 1'b0, rmode_q};
          `PDR_A_UPPER: o_rdata <= {16'h0000, upper_q};
          `PDR_A_LOWER: o_rdata <= {16'h0000, lower_q};
          `PDR_A_START: o_rdata <= {16'h0000, start_q};
          `PDR_A_STOP: o_rdata <= {16'h0000, stop_q};
          `PDR_A_GAIN: o_rdata <= {16'h0000, gain_q};
          `PDR_A_STATUS: o_rdata <= {24'h000000, fresh_q, o_output_on,
            o_fault, 2'h0, st_q};
          `PDR_A_IRQ: o_rdata <= {28'h0000000, stat_q};
          `PDR_A_MASK: o_rdata <= {28'h0000000, mask_q};
          `PDR_A_FREQ: o_rdata <= {16'h0000, o_freq_target};
          default: o_rdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// ### verification/pdr_chk_assertions.sv
// Assertion checker for the power-dip restart core
`timescale 1ns/1ns
`include "pdr_map.vh"
module pdr_chk (
  input wire i_clk, // Clock
  input wire i_resetn, // Reset, active low
  input wire [5:0] i_addr, // Register address
  input wire [31:0] i_wdata, // Write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  input wire i_large_drive, // Large capacity
  input wire i_undervolt, // Undervoltage
  input wire i_reset_cmd, // Fault reset
  input wire [31:0] o_rdata, // Read data
  input wire [15:0] o_freq_target, // Frequency target
  input wire o_output_on, // Output enabled
  input wire o_fault, // Fault
  input wire [7:0] o_fault_code, // Fault code
  input wire [1:0] o_brake_guard, // Guard select
  input wire o_irq // Interrupt
);
  reg [2:0] rmode_q;
  wire quiet = rmode_q == `PDR_M1 || rmode_q == `PDR_M4 || rmode_q == `PDR_M5;
  // Shadow of the restart mode that drops the writes the core must refuse
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rmode_q <= `PDR_MODE_RST;
    end else if (i_wr && i_addr == `PDR_A_MODE && i_wdata[2:0] <= `PDR_M5) begin
      rmode_q <= i_wdata[2:0];
    end
  end
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);
  a_fault_code: assert property (o_fault |-> o_fault_code == `PDR_UV_CODE)
    else $error("fault code wrong");
  a_guard_large: assert property (i_large_drive [*2] |=> o_brake_guard == `PDR_G_OFF)
    else $error("guard not off on large drive");
  a_guard_legal: assert property (o_brake_guard != 2'h3)
    else $error("guard value illegal");
  a_trip_now: assert property (rmode_q == `PDR_M0 && o_output_on && i_undervolt
    |=> o_fault && !o_output_on)
    else $error("no trip on undervoltage");
  a_dip_quiet: assert property (quiet && o_output_on && i_undervolt
    |=> !o_output_on && !o_fault)
    else $error("dip not a quiet stop");
  a_fault_hold: assert property (o_fault && !i_reset_cmd |=> o_fault)
    else $error("fault dropped without reset");
  a_fault_clear: assert property (o_fault && i_reset_cmd && !i_undervolt |=> !o_fault)
    else $error("reset did not clear fault");
  a_freq_cap: assert property (o_freq_target <= `PDR_FMAX_WIDE)
    else $error("target above ceiling");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside slot");
  c_rec_fault: cover property (rmode_q == `PDR_M1 && o_fault);
  c_irq: cover property ($rose(o_irq));
  c_ext: cover property (o_brake_guard == `PDR_G_EXT);
endmodule
bind pdr_core pdr_chk u_chk (.i_clk, .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd,
  .i_large_drive, .i_undervolt, .i_reset_cmd, .o_rdata, .o_freq_target, .o_output_on,
  .o_fault, .o_fault_code, .o_brake_guard, .o_irq);

// ### verification/pdr_op_env.sv
// Operator command and supply monitor model facing the restart core
`timescale 1ns/1ns
module pdr_op_env (
  input wire i_clk, // Clock
  output reg o_run = 1'b0, // Run command
  output reg o_reset_cmd = 1'b0, // Fault reset
  output reg [15:0] o_freq_cmd = 16'h0000, // Frequency command
  output reg o_undervolt = 1'b0, // Undervoltage seen
  output reg o_recovered = 1'b0, // Supply back
  output reg o_bus_low = 1'b0, // Bus at continue level
  output reg [7:0] o_deficit = 8'h00, // Bus shortfall
  output reg [15:0] o_speed = 16'h0000 // Coasting speed
);
  // Recovery is reported for one cycle only
  always @(posedge i_clk) begin
    if (o_recovered) begin
      o_recovered <= 1'b0;
    end
  end
  task cmd(input r, input [15:0] f);
    begin
      @(posedge i_clk);
      o_run <= r;
      o_freq_cmd <= f;
    end
  endtask
  task rst;
    begin
      @(posedge i_clk);
      o_reset_cmd <= 1'b1;
      @(posedge i_clk);
      o_reset_cmd <= 1'b0;
    end
  endtask
  // Bus sags first; a full failure brings undervoltage on top of it
  task sag;
    begin
      @(posedge i_clk);
      o_bus_low <= 1'b1;
      o_deficit <= 8'h10;
    end
  endtask
  task fail;
    begin
      @(posedge i_clk);
      o_bus_low <= 1'b1;
      o_undervolt <= 1'b1;
    end
  endtask
  task restore;
    begin
      @(posedge i_clk);
      o_bus_low <= 1'b0;
      o_undervolt <= 1'b0;
      o_deficit <= 8'h00;
      o_recovered <= 1'b1;
    end
  endtask
  task spin(input [15:0] s);
    begin
      @(posedge i_clk);
      o_speed <= s;
    end
  endtask
endmodule

// ### verification/tb.sv
// Self-checking bench for the power-dip restart core
`timescale 1ns/1ns
`include "pdr_map.vh"
module tb;
  reg i_clk = 1'b0;
  reg i_resetn = 1'b0;
  reg [5:0] i_addr = 6'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  reg i_large_drive = 1'b0;
  reg i_narrow_range = 1'b0;
  wire run, rcmd, uv, rec, bus_low;
  wire [15:0] fcmd, spd, o_freq_target;
  wire [7:0] def, o_fault_code;
  wire [31:0] o_rdata;
  wire o_output_on, o_fault, o_irq;
  wire [1:0] o_brake_guard;
  integer fail_count = 0;
  integer compares = 0;
  integer k, j;
  reg [31:0] v;
  always #2 i_clk = ~i_clk;
  pdr_op_env env (.i_clk(i_clk), .o_run(run), .o_reset_cmd(rcmd), .o_freq_cmd(fcmd),
    .o_undervolt(uv), .o_recovered(rec), .o_bus_low(bus_low), .o_deficit(def), .o_speed(spd));
  pdr_core i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .i_large_drive(i_large_drive), .i_narrow_range(i_narrow_range),
    .i_run(run), .i_reset_cmd(rcmd), .i_freq_cmd(fcmd), .i_undervolt(uv), .i_recovered(rec),
    .i_bus_low(bus_low), .i_bus_deficit(def), .i_motor_speed(spd), .o_rdata(o_rdata),
    .o_freq_target(o_freq_target), .o_output_on(o_output_on), .o_fault(o_fault),
    .o_fault_code(o_fault_code), .o_brake_guard(o_brake_guard), .o_irq(o_irq));
  task wrap_up;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      compares = compares + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge i_clk);
      #1;
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    begin
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
    end
  endtask
  // Read data stand only in the cycle after the strobe
  task rd(input [5:0] a);
    begin
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1;
      v = o_rdata;
    end
  endtask
  task wait_f(input [15:0] f);
    begin
      for (k = 0; k < 300 && o_freq_target !== f; k = k + 1) cyc(1);
      chk(o_freq_target, f);
      if (k == 300) wrap_up;
    end
  endtask
  task wait_on(input b);
    begin
      for (k = 0; k < 300 && o_output_on !== b; k = k + 1) cyc(1);
      chk(o_output_on, b);
      if (k == 300) wrap_up;
    end
  endtask
  task t_regs;
    begin
      rd(`PDR_A_MODE);
      chk(v, 32'h1000);
      rd(`PDR_A_UPPER);
      chk(v, 32'h0FA0);
      rd(`PDR_A_STOP);
      chk(v, 32'h0002);
      rd(6'h3C);
      chk(v, 32'h0);
      wr(`PDR_A_GAIN, 32'h1234);
      rd(`PDR_A_GAIN);
      chk(v, 32'h1234);
      for (j = 0; j < 6; j = j + 1) begin
        wr(`PDR_A_MODE, 32'h1000 | j);
        rd(`PDR_A_MODE);
        chk(v[2:0], j);
      end
      wr(`PDR_A_MODE, 32'h1006);
      rd(`PDR_A_MODE);
      chk(v[2:0], 32'h5);
      wr(`PDR_A_MODE, 32'h1010);
      cyc(3);
      chk(o_brake_guard, 32'h1);
      // A large drive must clear a guard that was already stored
      @(posedge i_clk);
      i_large_drive <= 1'b1;
      cyc(3);
      chk(o_brake_guard, 32'h0);
      wr(`PDR_A_MODE, 32'h1010);
      cyc(3);
      chk(o_brake_guard, 32'h0);
      @(posedge i_clk);
      i_large_drive <= 1'b0;
      wr(`PDR_A_MODE, 32'h1020);
      wr(`PDR_A_MODE, 32'h1030);
      cyc(3);
      chk(o_brake_guard, 32'h2);
      wr(`PDR_A_MODE, 32'h1000);
      $display("register test done");
    end
  endtask
  task t_clamp;
    begin
      wr(`PDR_A_LOWER, 32'h001E);
      wr(`PDR_A_UPPER, 32'h0014);
      env.cmd(1'b1, 16'h0064);
      wait_on(1'b1);
      chk(o_freq_target, 32'h0005);
      wait_f(16'h0014);
      wr(`PDR_A_UPPER, 32'hFFFF);
      rd(`PDR_A_UPPER);
      chk(v, 32'h0FA0);
      env.cmd(1'b1, 16'h0000);
      wait_f(16'h001E);
      env.cmd(1'b0, 16'h0000);
      wait_f(16'h0002);
      wait_on(1'b0);
      @(posedge i_clk);
      i_narrow_range <= 1'b1;
      wr(`PDR_A_UPPER, 32'h0FA0);
      rd(`PDR_A_UPPER);
      chk(v, 32'h04B0);
      @(posedge i_clk);
      i_narrow_range <= 1'b0;
      wr(`PDR_A_UPPER, 32'h0FA0);
      wr(`PDR_A_LOWER, 32'h0);
      $display("clamp test done");
    end
  endtask
  task t_refuse;
    begin
      wr(`PDR_A_START, 32'h0001);
      env.cmd(1'b1, 16'h0032);
      cyc(4);
      chk(o_output_on, 32'h0);
      chk(o_irq, 32'h0);
      rd(`PDR_A_IRQ);
      chk(v[3], 32'h1);
      wr(`PDR_A_MASK, 32'h0008);
      cyc(2);
      chk(o_irq, 32'h1);
      wr(`PDR_A_IRQ, 32'h0008);
      cyc(2);
      chk(o_irq, 32'h0);
      env.cmd(1'b0, 16'h0032);
      wr(`PDR_A_START, 32'h0005);
      env.cmd(1'b1, 16'h0032);
      wait_f(16'h0032);
      $display("refusal test done");
    end
  endtask
  task rerun;
    begin
      env.cmd(1'b0, 16'h0032);
      env.cmd(1'b1, 16'h0032);
      wait_f(16'h0032);
    end
  endtask
  task t_dips;
    begin
      wr(`PDR_A_MODE, 32'h1000);
      env.fail;
      cyc(2);
      chk({o_fault, o_output_on, o_fault_code}, 32'h24C);
      chk(o_freq_target, 32'h0);
      env.restore;
      env.rst;
      cyc(3);
      chk({o_fault, o_output_on}, 32'h0);
      rerun;
      wr(`PDR_A_MODE, 32'h1001);
      env.fail;
      cyc(2);
      chk({o_fault, o_output_on}, 32'h0);
      env.restore;
      cyc(1);
      chk(o_fault, 32'h1);
      env.rst;
      wait_on(1'b1);
      wait_f(16'h0032);
      for (j = 4; j < 6; j = j + 1) begin
        wr(`PDR_A_MODE, 32'h1000 | j);
        env.fail;
        cyc(2);
        chk({o_fault, o_output_on}, 32'h0);
        env.restore;
        wait_on(1'b1);
        chk(o_freq_target, j == 4 ? 32'h0032 : 32'h0005);
        wait_f(16'h0032);
      end
      env.spin(16'h0100);
      wr(`PDR_A_MODE, 32'h3004);
      env.fail;
      cyc(2);
      env.restore;
      wait_on(1'b1);
      chk(o_freq_target, 32'h0100);
      wait_f(16'h0032);
      // Speed above the pickup span falls back to the held frequency
      env.spin(16'h07D0);
      env.fail;
      cyc(2);
      env.restore;
      wait_on(1'b1);
      chk(o_freq_target, 32'h0032);
      $display("dip test done");
    end
  endtask
  task t_bus;
    begin
      wr(`PDR_A_MODE, 32'h1003);
      env.sag;
      cyc(2);
      chk(o_freq_target, 32'h002D);
      cyc(1);
      chk(o_freq_target, 32'h001C);
      cyc(3);
      chk(o_freq_target < 16'h0032, 32'h1);
      env.restore;
      wait_f(16'h0032);
      env.sag;
      cyc(2);
      env.fail;
      cyc(2);
      chk({o_fault, o_output_on}, 32'h0);
      env.restore;
      wait_on(1'b1);
      chk(o_freq_target, 32'h001C);
      wait_f(16'h0032);
      wr(`PDR_A_MODE, 32'h1002);
      env.sag;
      cyc(6);
      chk(o_freq_target <= 16'h0028, 32'h1);
      wait_on(1'b0);
      cyc(1);
      chk(o_fault, 32'h1);
      env.restore;
      env.rst;
      rerun;
      // Undervoltage during the controlled stop trips at once
      env.sag;
      cyc(2);
      env.fail;
      cyc(2);
      chk({o_fault, o_output_on, o_freq_target}, 32'h20000);
      env.restore;
      env.rst;
      rerun;
      wr(`PDR_A_MODE, 32'h1104);
      env.fail;
      cyc(2);
      chk({o_fault, o_output_on}, 32'h0);
      env.restore;
      cyc(1);
      chk(o_fault, 32'h1);
      $display("bus test done");
    end
  endtask
  initial begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    t_regs;
    t_clamp;
    t_refuse;
    t_dips;
    t_bus;
    wrap_up;
  end
endmodule
